// *** rtl/host_mode_cfg.svh ***
`ifndef HOST_MODE_CFG_SVH
`define HOST_MODE_CFG_SVH
// Register offset and field layout of the operating mode register
`define HOM_OFFSET        8'h04
`define HOM_RESET         32'h0000_0000
`define HOM_WAKE_EN_BIT   10
`define HOM_WAKE_CONN_BIT 9
`define HOM_IRQ_ROUTE_BIT 8
`define HOM_FSTATE_HI     7
`define HOM_FSTATE_LO     6
`define HOM_BULK_BIT      5
`define HOM_CTRL_BIT      4
`define HOM_ISO_BIT       3
`define HOM_PERIODIC_BIT  2
`define HOM_RATIO_HI      1
`define HOM_RATIO_LO      0
`define HOM_USED_MASK     32'h0000_07FF
// Start-of-frame delay after entering the running state
`define SOF_DELAY_US      1000
`define CLK_MHZ           50
`define SOF_DELAY_CYC     (`SOF_DELAY_US * `CLK_MHZ)
`endif

// *** rtl/host_mode_pkg.sv ***
package host_mode_pkg;
  // Functional state encoding
  typedef enum logic [1:0] {
    bus_reset_state = 2'h0,
    resume_state    = 2'h1,
    running_state   = 2'h2,
    suspended_state = 2'h3
  } functional_state_t;

  // Register access request from the register port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  // List enables seen by the schedule engine
  typedef struct packed {
    logic       bulk_queue_on;
    logic       ctrl_queue_on;
    logic       iso_on;
    logic       periodic_queue_on;
    logic [1:0] ctrl_bulk_ratio;
  } list_enables_t;
endpackage : host_mode_pkg

// *** rtl/frame_start_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "host_mode_cfg.svh"
// Counts the delay from entering the running state to the first frame start
module frame_start_timer #(
  parameter int unsigned DELAY_CYC = `SOF_DELAY_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic running,
  output logic      sof_active
);
  logic [31:0] count_q;

  // Restart on each entry to running, abort if running is left
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_q    <= 32'h0000_0000;
      sof_active <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        count_q    <= 32'h0000_0000;
        sof_active <= 1'b0;
      end else if (start) begin
        count_q    <= 32'h0000_0001;
        sof_active <= 1'b0;
      end else if (!sof_active && count_q != 32'h0000_0000) begin
        if (count_q >= DELAY_CYC) begin
          sof_active <= 1'b1;
          count_q    <= 32'h0000_0000;
        end else begin
          count_q <= count_q + 32'h0000_0001;
        end
      end
    end
  end
endmodule : frame_start_timer
`default_nettype wire

// *** rtl/host_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "host_mode_cfg.svh"
module host_mode_ctrl #(
  parameter int unsigned SOF_DELAY = `SOF_DELAY_CYC
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  input  wire logic                         soft_reset,
  input  wire host_mode_pkg::reg_req_t      reg_req,
  output logic [31:0]                       reg_rdata,
  input  wire logic                         resume_flag,
  input  wire logic                         irq_event,
  input  wire logic                         downstream_resume,
  input  wire logic                         frame_boundary,
  input  wire logic                         iso_desc_seen,
  input  wire logic                         ctrl_desc_served,
  input  wire logic                         nonperiodic_start,
  output logic                              remote_wake,
  output logic                              host_irq,
  output logic                              mgmt_irq,
  output logic                              root_hub_reset,
  output logic                              frame_start_flag,
  output host_mode_pkg::list_enables_t      frame_enables,
  output logic                              iso_continue,
  output logic                              serve_control,
  output logic [1:0]                        functional_state
);
  logic                              wake_en_q;
  logic                              wake_conn_q;
  logic                              irq_route_q;
  host_mode_pkg::functional_state_t  fstate_q;
  host_mode_pkg::functional_state_t  fstate_d;
  host_mode_pkg::list_enables_t      en_q;
  logic [2:0]                        ctrl_count_q;
  logic                              wr_hit;
  logic                              enter_run;
  logic                              sof_active;

  // Register address decode, used for both writes and reads
  function automatic logic hit(input host_mode_pkg::reg_req_t r);
    hit = (r.addr == `HOM_OFFSET);
  endfunction : hit

  // Control keeps the turn while fewer than ratio+1 descriptors were served
  function automatic logic ctrl_turn(input logic [2:0] count, input logic [1:0] ratio);
    ctrl_turn = (count <= {1'b0, ratio});
  endfunction : ctrl_turn

  assign wr_hit = reg_req.wr && hit(reg_req);

  // Software-only fields: written and read back by software, hardware never touches them
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wake_en_q <= 1'b0;
      en_q      <= '0;
    end else if (ce && wr_hit) begin
      wake_en_q            <= reg_req.wdata[`HOM_WAKE_EN_BIT];
      en_q.bulk_queue_on   <= reg_req.wdata[`HOM_BULK_BIT];
      en_q.ctrl_queue_on   <= reg_req.wdata[`HOM_CTRL_BIT];
      en_q.iso_on          <= reg_req.wdata[`HOM_ISO_BIT];
      en_q.periodic_queue_on <= reg_req.wdata[`HOM_PERIODIC_BIT];
      en_q.ctrl_bulk_ratio <= reg_req.wdata[`HOM_RATIO_HI:`HOM_RATIO_LO];
    end
  end

  // Connected and routing bits survive a software reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wake_conn_q <= 1'b0;
      irq_route_q <= 1'b0;
    end else if (ce && wr_hit) begin
      wake_conn_q <= reg_req.wdata[`HOM_WAKE_CONN_BIT];
      irq_route_q <= reg_req.wdata[`HOM_IRQ_ROUTE_BIT];
    end
  end

  // Functional state: software write, software reset, or resume detect
  always_comb begin
    fstate_d = fstate_q;
    if (soft_reset) begin
      fstate_d = host_mode_pkg::suspended_state;
    end else if (wr_hit) begin
      fstate_d = host_mode_pkg::functional_state_t'(
        reg_req.wdata[`HOM_FSTATE_HI:`HOM_FSTATE_LO]);
    end else if (fstate_q == host_mode_pkg::suspended_state
                 && downstream_resume) begin
      fstate_d = host_mode_pkg::resume_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fstate_q <= host_mode_pkg::bus_reset_state;
    end else if (ce) begin
      fstate_q <= fstate_d;
    end
  end

  assign enter_run = (fstate_d == host_mode_pkg::running_state)
                     && (fstate_q != host_mode_pkg::running_state);

  // Frame-start delay after entering running
  frame_start_timer #(
    .DELAY_CYC (SOF_DELAY)
  ) u_sof_timer (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .ce         (ce),
    .start      (enter_run),
    .running    (fstate_d == host_mode_pkg::running_state),
    .sof_active (sof_active)
  );

  // Enables latched at frame boundary, so changes apply next frame
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frame_enables <= '0;
    end else if (ce && frame_boundary) begin
      frame_enables <= en_q;
    end
  end

  // Iso descriptor check against the frame copy of the iso enable
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      iso_continue <= 1'b0;
    end else if (ce && iso_desc_seen) begin
      iso_continue <= frame_enables.iso_on;
    end
  end

  // Control service count kept across frames, cleared when bulk takes its turn
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_count_q <= 3'h0;
    end else if (ce) begin
      if (nonperiodic_start && !ctrl_turn(ctrl_count_q, frame_enables.ctrl_bulk_ratio)) begin
        ctrl_count_q <= 3'h0;
      end else if (ctrl_desc_served && ctrl_count_q != 3'h4) begin
        ctrl_count_q <= ctrl_count_q + 3'h1;
      end
    end
  end

  // Control or bulk decision taken before nonperiodic processing
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serve_control <= 1'b0;
    end else if (ce && nonperiodic_start) begin
      serve_control <= frame_enables.ctrl_queue_on
                       && ctrl_turn(ctrl_count_q, frame_enables.ctrl_bulk_ratio);
    end
  end

  // Interrupt routing and wake signalling
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      host_irq    <= 1'b0;
      mgmt_irq    <= 1'b0;
      remote_wake <= 1'b0;
    end else if (ce) begin
      host_irq    <= irq_event && !irq_route_q;
      mgmt_irq    <= irq_event && irq_route_q;
      remote_wake <= wake_en_q && resume_flag;
    end
  end

  // Root hub reset follows the bus reset state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      root_hub_reset <= 1'b1;
    end else if (ce) begin
      root_hub_reset <= (fstate_d == host_mode_pkg::bus_reset_state);
    end
  end

  // Status outputs and read data
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frame_start_flag <= 1'b0;
      functional_state <= 2'h0;
      reg_rdata        <= `HOM_RESET;
    end else if (ce) begin
      frame_start_flag <= sof_active;
      functional_state <= fstate_d;
      if (reg_req.rd && hit(reg_req)) begin
        reg_rdata <= {21'h000000, wake_en_q, wake_conn_q, irq_route_q, fstate_q,
                      en_q.bulk_queue_on, en_q.ctrl_queue_on, en_q.iso_on,
                      en_q.periodic_queue_on, en_q.ctrl_bulk_ratio};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end
endmodule : host_mode_ctrl
`default_nettype wire

// *** verif/host_mode_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_mode_ctrl_asserts (
  input wire logic                         clk_sys,
  input wire logic                         rst_b,
  input wire logic                         ce,
  input wire logic                         soft_reset,
  input wire host_mode_pkg::reg_req_t      reg_req,
  input wire logic                         irq_event,
  input wire logic                         downstream_resume,
  input wire logic                         frame_boundary,
  input wire logic                         iso_desc_seen,
  input wire logic                         host_irq,
  input wire logic                         mgmt_irq,
  input wire logic                         root_hub_reset,
  input wire logic                         frame_start_flag,
  input wire host_mode_pkg::list_enables_t frame_enables,
  input wire logic                         iso_continue,
  input wire logic [1:0]                   functional_state
);
  // All checks share the system clock and its reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_IRQ_ROUTE: assert property (ce && irq_event |=> host_irq != mgmt_irq)
    else $error("interrupt not routed to exactly one output");
  AST_HW_RESET: assert property ($rose(rst_b) |-> functional_state == 2'h0 && root_hub_reset)
    else $error("hardware reset left wrong state");
  AST_SOFT: assert property (ce && soft_reset |=> functional_state == 2'h3)
    else $error("soft reset did not suspend");
  AST_HW_CHANGE: assert property (($changed(functional_state) && !$past(reg_req.wr) && !$past(soft_reset)) |-> $past(functional_state) == 2'h3 && functional_state == 2'h1)
    else $error("state changed by hardware outside suspend");
  AST_RESUME: assert property (ce && functional_state == 2'h3 && downstream_resume && !reg_req.wr && !soft_reset |=> functional_state == 2'h1)
    else $error("no move to resume");
  AST_FRAME_HOLD: assert property (!(ce && frame_boundary) |=> $stable(frame_enables))
    else $error("enables changed inside a frame");
  AST_ISO: assert property (ce && iso_desc_seen |=> iso_continue == $past(frame_enables.iso_on))
    else $error("iso decision wrong");
  AST_SOF_LATE: assert property ($rose(functional_state == 2'h2) |-> !frame_start_flag [*8])
    else $error("frame start too early");
  // Main scenarios reached
  cover property (ce && soft_reset);
  cover property (functional_state == 2'h3 ##1 functional_state == 2'h1);
  cover property ($rose(frame_start_flag));
endmodule : host_mode_ctrl_asserts
bind host_mode_ctrl host_mode_ctrl_asserts chk_u (.*);
`default_nettype wire

// *** verif/host_driver_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "host_mode_cfg.svh"
module host_driver_model (
  input  wire logic              clk_sys,
  input  wire logic [31:0]       reg_rdata,
  output host_mode_pkg::reg_req_t reg_req
);
  // Bus idle until an access is issued
  initial reg_req = '0;
  // One-cycle write, reserved bits sent as zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d & `HOM_USED_MASK};
    @(posedge clk_sys) reg_req <= '0;
    #1;
  endtask : wr
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys) reg_req <= '0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_driver_model
`default_nettype wire

// *** verif/usb_host_ctrl_mode_register_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_host_ctrl_mode_register_tb;
  logic                         clk_sys = 1'b0;
  logic                         rst_b = 1'b0;
  logic [4:0]                   ev = '0;
  logic [2:0]                   lv = '0;
  logic [31:0]                  rdata, reg_rdata;
  host_mode_pkg::reg_req_t      reg_req;
  host_mode_pkg::list_enables_t frame_enables;
  logic [1:0]                   functional_state;
  logic                         remote_wake, host_irq, mgmt_irq, root_hub_reset;
  logic                         frame_start_flag, iso_continue, serve_control;
  int                           bad_count = 0;
  int                           checks_done = 0;
  int                           n;
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  host_mode_ctrl #(.SOF_DELAY(20)) dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .soft_reset(ev[4]), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .resume_flag(lv[2]), .irq_event(lv[1]),
    .downstream_resume(lv[0]), .frame_boundary(ev[3]), .iso_desc_seen(ev[2]),
    .ctrl_desc_served(ev[1]), .nonperiodic_start(ev[0]), .remote_wake(remote_wake),
    .host_irq(host_irq), .mgmt_irq(mgmt_irq), .root_hub_reset(root_hub_reset),
    .frame_start_flag(frame_start_flag), .frame_enables(frame_enables),
    .iso_continue(iso_continue), .serve_control(serve_control),
    .functional_state(functional_state));
  host_driver_model drv_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_req(reg_req));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle event pulse
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_sys) ev <= m;
    @(posedge clk_sys) ev <= '0;
    #1;
  endtask : pulse
  // Apply status levels and let the registered outputs follow
  task automatic hold(input logic [2:0] v);
    @(posedge clk_sys) lv <= v;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : hold
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // Cut a hang short
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk(functional_state, 2'h0);
    chk(root_hub_reset, 1'b1);
    drv_u.rd(8'h04, rdata);
    chk(rdata, 32'h0);
    for (int i = 0; i < 4; i++) begin
      drv_u.wr(8'h04, 32'(i) << 6);
      chk(functional_state, i[1:0]);
    end
    drv_u.wr(8'h04, 32'h7BF);
    chk(frame_enables, 6'h0);
    pulse(5'h08);
    chk(frame_enables, 6'h3F);
    pulse(5'h04);
    chk(iso_continue, 1'b1);
    pulse(5'h01);
    chk(serve_control, 1'b1);
    n = 0;
    while (frame_start_flag !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n > 8 && n < 30, 1'b1);
    for (int i = 0; i < 4; i++) pulse((i == 1) ? 5'h0A : 5'h02);
    pulse(5'h01);
    chk(serve_control, 1'b0);
    pulse(5'h01);
    chk(serve_control, 1'b1);
    hold(3'b110);
    chk({remote_wake, host_irq, mgmt_irq}, 3'b101);
    pulse(5'h10);
    chk(functional_state, 2'h3);
    drv_u.rd(8'h04, rdata);
    chk(rdata, 32'h7FF);
    hold(3'b001);
    chk(functional_state, 2'h1);
    drv_u.wr(8'h04, 32'h280);
    hold(3'b111);
    chk({remote_wake, host_irq, mgmt_irq}, 3'b010);
    chk(functional_state, 2'h2);
    drv_u.wr(8'h08, 32'h7FF);
    drv_u.rd(8'h08, rdata);
    chk(rdata, 32'h0);
    drv_u.rd(8'h04, rdata);
    chk(rdata, 32'h280);
    @(posedge clk_sys) rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    drv_u.rd(8'h04, rdata);
    chk(rdata, 32'h0);
    finish_test();
  end
endmodule : usb_host_ctrl_mode_register_tb
`default_nettype wire
